// *** src/relay_pkg.sv ***
// Summary of operation
// - Per-relay active level, default 1, sets polarity.
// - Safety assignments force active level to 1.
// - Holding delay 0..9999 ms on event fall.
// - Safety assignments force holding delay 0, writes refused.
// - Activation delay 0..60000 ms on event rise.
// - Fallback forced off when an event is assigned.
// - Assigned relay follows its event, not fieldbus.
// - Unassigned, no fallback: follow fieldbus, hold on error.
// - Fallback enabled: follow fieldbus, off on error.
// - Delays and level still apply under error.
`default_nettype none
package relay_pkg;
	localparam int NUM_RELAYS = 6; // Relay outputs
	localparam int NUM_EVENTS = 8; // Event selector range
	localparam int CLK_PERIOD_NS = 40; // 25 MHz system clock
	localparam int TIMEBASE_NS = 1_000_000; // 1 ms delay step
	localparam int TICK_CYCLES = TIMEBASE_NS / CLK_PERIOD_NS; // Cycles per ms
	localparam logic [15:0] ACT_DLY_MAX = 16'hEA60; // 60000 ms
	localparam logic [15:0] HOLD_DLY_MAX = 16'h270F; // 9999 ms
	localparam logic [15:0] DLY_RST = 16'h0000; // Both delays reset to 0 ms
	localparam logic LEVEL_RST = 1'b1; // Active level reset value
	localparam logic FALLBACK_RST = 1'b0; // Fallback reset value
	localparam logic [7:0] CFG_BASE = 8'h00; // Config words, one per relay
	localparam logic [7:0] DLY_BASE = 8'h20; // Delay words, one per relay
	localparam logic [7:0] STATUS_ADDR = 8'h40; // Read-only status
	localparam int CFG_SEL_LSB = 0; // Event selector [2:0]
	localparam int CFG_LEVEL_BIT = 4; // Active level
	localparam int CFG_FB_BIT = 5; // Fallback enable
	localparam int DLY_ACT_LSB = 0; // Activation delay [15:0]
	localparam int DLY_HOLD_LSB = 16; // Holding delay [31:16]
	localparam int ST_OUT_LSB = 0; // Relay outputs [5:0]
	localparam int ST_SRC_LSB = 8; // Pre-delay sources [13:8]
	localparam int ST_ERR_BIT = 16; // Error input level
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10; // AHB transfer type

	// Event assignment codes
	typedef enum logic [2:0] {
		EV_NONE = 3'b000,
		EV_FAULT = 3'b001,
		EV_MAINS = 3'b010,
		EV_DC_CHARGE = 3'b011,
		EV_BRAKE = 3'b100,
		EV_OUT_CONT = 3'b101,
		EV_GEN_A = 3'b110,
		EV_GEN_B = 3'b111
	} relay_event_e;

	// Per-relay settings
	typedef struct packed {
		relay_event_e evtSel;
		logic activeHigh;
		logic fallbackEn;
		logic [15:0] actDly;
		logic [15:0] holdDly;
	} relay_cfg_s;

	// Captured AHB address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ahb_aphase_s;

	// True for assignments with fixed safety settings
	function automatic logic isSafety(input relay_event_e sel);
		isSafety = (sel >= EV_FAULT) && (sel <= EV_OUT_CONT);
	endfunction

	// Saturate a written delay to its range
	function automatic logic [15:0] clampDly(input logic [15:0] v, input logic [15:0] lim);
		clampDly = (v > lim) ? lim : v;
	endfunction
endpackage
`default_nettype wire

// *** src/relay_output_conditioner.sv ***
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module relay_output_conditioner #(
	parameter int TickCycles = relay_pkg::TICK_CYCLES // Cycles per 1 ms step
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [relay_pkg::NUM_EVENTS-1:0] evtIn,
	input wire logic [relay_pkg::NUM_RELAYS-1:0] fbCmd,
	input wire logic errDet,
	output logic [relay_pkg::NUM_RELAYS-1:0] relayOut
);
	import relay_pkg::*;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	relay_cfg_s cfg_q [NUM_RELAYS]; // Settings per relay
	ahb_aphase_s aph_q; // Pending data phase
	logic [31:0] hrdata_q; // Read data register
	logic [NUM_RELAYS-1:0] src; // Signal before delays
	logic [NUM_RELAYS-1:0] filt_q; // Signal after delays
	logic [NUM_RELAYS-1:0] heldCmd_q; // Fieldbus bits before error
	logic [NUM_RELAYS-1:0] relayOut_q; // Coil drive register
	logic [15:0] cnt_q [NUM_RELAYS]; // Delay counters in ms
	logic [31:0] tickCnt_q; // Timebase divider
	logic tick; // 1 ms enable pulse
	logic [2:0] unusedSize; // Only word transfers used

	assign unusedSize = hsize;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign relayOut = relayOut_q;

	// Relay index from a word address within a bank
	function automatic int relayIdx(input logic [7:0] a, input logic [7:0] base);
		relayIdx = int'((a - base) >> 2);
	endfunction

	// Register read mux
	function automatic logic [31:0] readMux(input logic [7:0] a);
		logic [31:0] r;
		int k;
		r = 32'h0000_0000;
		if (a == STATUS_ADDR) begin
			r[ST_OUT_LSB +: NUM_RELAYS] = relayOut_q;
			r[ST_SRC_LSB +: NUM_RELAYS] = src;
			r[ST_ERR_BIT] = errDet;
		end else if (a >= CFG_BASE && a < CFG_BASE + 8'(4 * NUM_RELAYS) && a[1:0] == 2'b00) begin
			k = relayIdx(a, CFG_BASE);
			r[CFG_SEL_LSB +: 3] = cfg_q[k].evtSel;
			r[CFG_LEVEL_BIT] = cfg_q[k].activeHigh;
			r[CFG_FB_BIT] = cfg_q[k].fallbackEn;
		end else if (a >= DLY_BASE && a < DLY_BASE + 8'(4 * NUM_RELAYS) && a[1:0] == 2'b00) begin
			k = relayIdx(a, DLY_BASE);
			r[DLY_ACT_LSB +: 16] = cfg_q[k].actDly;
			r[DLY_HOLD_LSB +: 16] = cfg_q[k].holdDly;
		end
		readMux = r;
	endfunction

	// Address phase capture and read data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aph_q <= '0;
			hrdata_q <= 32'h0000_0000;
		end else if (hready) begin
			aph_q.valid <= hsel && htrans == HTRANS_NONSEQ;
			aph_q.write <= hwrite;
			aph_q.addr <= haddr[7:0];
			if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
				hrdata_q <= readMux(haddr[7:0]);
			end
		end
	end

	// Register writes with forced safety settings
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_RELAYS; i++) begin
				cfg_q[i] <= '{EV_NONE, LEVEL_RST, FALLBACK_RST, DLY_RST, DLY_RST};
			end
		end else if (aph_q.valid && aph_q.write) begin
			for (int i = 0; i < NUM_RELAYS; i++) begin
				// Config word
				if (aph_q.addr == CFG_BASE + 8'(4 * i)) begin
					cfg_q[i].evtSel <= relay_event_e'(hwdata[CFG_SEL_LSB +: 3]);
					if (isSafety(relay_event_e'(hwdata[CFG_SEL_LSB +: 3]))) begin
						cfg_q[i].activeHigh <= 1'b1;
						cfg_q[i].holdDly <= DLY_RST;
					end else begin
						cfg_q[i].activeHigh <= hwdata[CFG_LEVEL_BIT];
					end
					// Fallback only for unassigned relays
					cfg_q[i].fallbackEn <= (hwdata[CFG_SEL_LSB +: 3] == EV_NONE) && hwdata[CFG_FB_BIT];
				end else if (aph_q.addr == DLY_BASE + 8'(4 * i)) begin
					cfg_q[i].actDly <= clampDly(hwdata[DLY_ACT_LSB +: 16], ACT_DLY_MAX);
					// Holding delay write refused on safety relays
					if (!isSafety(cfg_q[i].evtSel)) begin
						cfg_q[i].holdDly <= clampDly(hwdata[DLY_HOLD_LSB +: 16], HOLD_DLY_MAX);
					end
				end
			end
		end
	end

	// 1 ms timebase divider
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_q <= 32'h0000_0000;
		end else if (tickCnt_q >= 32'(TickCycles - 1)) begin
			tickCnt_q <= 32'h0000_0000;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h0000_0001;
		end
	end
	assign tick = tickCnt_q >= 32'(TickCycles - 1);

	// Fieldbus bits frozen while an error is present
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			heldCmd_q <= '0;
		end else if (!errDet) begin
			heldCmd_q <= fbCmd;
		end
	end

	// Source selection per relay
	always_comb begin
		for (int i = 0; i < NUM_RELAYS; i++) begin
			if (cfg_q[i].evtSel != EV_NONE) begin
				src[i] = evtIn[cfg_q[i].evtSel];
			end else if (cfg_q[i].fallbackEn) begin
				src[i] = errDet ? 1'b0 : fbCmd[i];
			end else begin
				src[i] = errDet ? heldCmd_q[i] : fbCmd[i];
			end
		end
	end

	// Delays and level, applied to every source including error states
	for (genvar g = 0; g < NUM_RELAYS; g++) begin : gRelay
		logic [15:0] target; // Delay for the pending change
		assign target = src[g] ? cfg_q[g].actDly : cfg_q[g].holdDly;

		// Delay counter and filtered state
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				cnt_q[g] <= 16'h0000;
				filt_q[g] <= 1'b0;
			end else if (src[g] == filt_q[g]) begin
				cnt_q[g] <= 16'h0000;
			end else if (target == 16'h0000 || cnt_q[g] > target) begin
				// Count one tick past the setting, as the first tick may come at once
				filt_q[g] <= src[g];
				cnt_q[g] <= 16'h0000;
			end else if (tick) begin
				cnt_q[g] <= cnt_q[g] + 16'h0001;
			end
		end

		// Output polarity
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				relayOut_q[g] <= 1'b0;
			end else begin
				relayOut_q[g] <= cfg_q[g].activeHigh ? filt_q[g] : !filt_q[g];
			end
		end

		sequence srcSteady;
			$stable(src[g]) && $stable(cfg_q[g].activeHigh) && target == 16'h0000;
		endsequence
		sequence fbErrOff;
			cfg_q[g].evtSel == EV_NONE && cfg_q[g].fallbackEn && errDet && target == 16'h0000;
		endsequence

		level_forced_a: assert property (isSafety(cfg_q[g].evtSel) |-> cfg_q[g].activeHigh)
			else $error("safety relay level not forced");
		hold_forced_a: assert property (isSafety(cfg_q[g].evtSel) |-> cfg_q[g].holdDly == 16'h0000)
			else $error("safety relay hold delay not zero");
		fallback_off_a: assert property (cfg_q[g].evtSel != EV_NONE |-> !cfg_q[g].fallbackEn)
			else $error("fallback enabled on assigned relay");
		level_follow_a: assert property (srcSteady [*3] |-> relayOut_q[g] == (cfg_q[g].activeHigh ? src[g] : !src[g]))
			else $error("relay output does not reflect source and level");
		fallback_error_a: assert property (fbErrOff [*3] |-> relayOut_q[g] == !cfg_q[g].activeHigh)
			else $error("fallback error did not drive relay inactive");
		error_hold_a: assert property (cfg_q[g].evtSel == EV_NONE && !cfg_q[g].fallbackEn && errDet
			&& $past(errDet) && $stable(cfg_q[g].evtSel) |-> $stable(src[g]))
			else $error("relay source moved during error");
		event_source_a: assert property (cfg_q[g].evtSel != EV_NONE |-> src[g] == evtIn[cfg_q[g].evtSel])
			else $error("assigned relay not following its event");
		rise_delay_a: assert property ($rose(filt_q[g]) |-> $past(cnt_q[g]) >= $past(cfg_q[g].actDly))
			else $error("relay activated before activation delay");
		fall_delay_a: assert property ($fell(filt_q[g]) |-> $past(cnt_q[g]) >= $past(cfg_q[g].holdDly))
			else $error("relay released before holding delay");
		cancel_pending_a: assert property (src[g] != filt_q[g] ##1 src[g] == filt_q[g] |=> cnt_q[g] == 16'h0000 && $stable(filt_q[g]))
			else $error("cancelled change still took effect");
	end

endmodule // relay_output_conditioner
`default_nettype wire

// *** bench/relay_fieldbus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Fieldbus side: re-times the command word and the link-loss flag to mclk
module relay_fieldbus_model (
	input wire logic mclk,
	input wire logic [relay_pkg::NUM_RELAYS-1:0] cmdWord,
	input wire logic commLost,
	output logic [relay_pkg::NUM_RELAYS-1:0] fbCmd,
	output logic errDet
);
	// The word is not cleared on a link loss, so the block must hold
	always_ff @(posedge mclk) begin
		fbCmd <= cmdWord;
		errDet <= commLost;
	end
endmodule // relay_fieldbus_model
`default_nettype wire

// *** bench/relay_output_conditioner_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module relay_output_conditioner_test;
	import relay_pkg::*;
	logic mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, commLost = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, errDet;
	logic [7:0] evtIn = 0;
	logic [5:0] cmdWord = 0, fbCmd, relayOut;
	int num_errors = 0, total_checks = 0;
	// Short tick keeps the ms delays cheap: 4 cycles per step
	relay_output_conditioner #(.TickCycles(4)) DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evtIn(evtIn), .fbCmd(fbCmd),
		.errDet(errDet), .relayOut(relayOut));
	relay_fieldbus_model farSide (.mclk(mclk), .cmdWord(cmdWord), .commLost(commLost), .fbCmd(fbCmd),
		.errDet(errDet));
	// 25 MHz clock
	always #20 mclk = ~mclk;
	// Closing verdict
	task report_and_stop;
		if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Compare and count
	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Next edge with hready high, bounded
	task edgeRdy;
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				num_errors++;
				report_and_stop;
			end
			@(posedge mclk);
		end
	endtask
	// Single word write
	task ahbWr(input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0000_00, a};
		hwrite <= 1;
		htrans <= HTRANS_NONSEQ;
		hsel <= 1;
		edgeRdy;
		htrans <= 2'b00;
		hwdata <= d;
		edgeRdy;
	endtask
	// Single word read, compared to expectation
	task ahbRd(input logic [7:0] a, input logic [31:0] exp);
		haddr <= {24'h0000_00, a};
		hwrite <= 0;
		htrans <= HTRANS_NONSEQ;
		hsel <= 1;
		edgeRdy;
		htrans <= 2'b00;
		edgeRdy;
		rd = hrdata;
		check("hrdata", rd, exp);
		check("hresp", {31'h0, hresp}, 0);
	endtask
	// Edges until relay i shows v, must land in lo..hi
	task lat(input int i, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (relayOut[i] !== v && n <= hi) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("latency", {31'h0, n >= lo && n <= hi}, 1);
	endtask
	// Reset values and unmapped places
	task resetValues;
		check("relayOut", {26'h0, relayOut}, 0);
		ahbRd(CFG_BASE, 32'h0000_0010);
		ahbRd(DLY_BASE, 32'h0000_0000);
		ahbWr(8'h80, 32'hFFFF_FFFF);
		ahbRd(8'h80, 32'h0000_0000);
		ahbWr(8'h44, 32'h0000_0000);
	endtask
	// Unassigned relay 0 follows bus, holds on error
	task busHold;
		cmdWord <= 6'h01;
		lat(0, 1, 3, 3);
		commLost <= 1;
		cmdWord <= 6'h00;
		repeat (8) @(posedge mclk);
		check("hold", {31'h0, relayOut[0]}, 1);
		ahbRd(STATUS_ADDR, 32'h0001_0101);
		commLost <= 0;
		lat(0, 0, 2, 4);
	endtask
	// Fallback relay 1 level 1 and relay 2 level 0
	task fallback;
		ahbWr(CFG_BASE + 8'h04, 32'h0000_0030);
		ahbWr(CFG_BASE + 8'h08, 32'h0000_0020);
		lat(2, 1, 1, 3);
		cmdWord <= 6'h06;
		lat(1, 1, 3, 3);
		lat(2, 0, 0, 1);
		commLost <= 1;
		lat(1, 0, 3, 3);
		lat(2, 1, 0, 1);
		commLost <= 0;
		cmdWord <= 6'h00;
		repeat (4) @(posedge mclk);
	endtask
	// Safety assignment on relay 3 forces level, fallback, hold
	task safety;
		ahbWr(CFG_BASE + 8'h0C, {29'h0, EV_BRAKE} | 32'h0000_0020);
		ahbRd(CFG_BASE + 8'h0C, 32'h0000_0014);
		ahbWr(DLY_BASE + 8'h0C, 32'h0005_0003);
		ahbRd(DLY_BASE + 8'h0C, 32'h0000_0003);
		cmdWord <= 6'h08;
		evtIn <= 8'h10;
		lat(3, 1, 14, 19);
		evtIn <= 8'h00;
		lat(3, 0, 2, 2);
	endtask
	// Hold delay and cancel on a general event, saturation on unassigned relay 5
	task holdCancel;
		int n;
		ahbWr(CFG_BASE + 8'h10, {29'h0, EV_GEN_A} | 32'h0000_0010);
		ahbWr(DLY_BASE + 8'h10, 32'h0002_0000);
		evtIn <= 8'h40;
		lat(4, 1, 2, 2);
		evtIn <= 8'h00;
		lat(4, 0, 10, 15);
		evtIn <= 8'h40;
		lat(4, 1, 2, 2);
		evtIn <= 8'h00;
		repeat (3) @(posedge mclk);
		evtIn <= 8'h40;
		n = 0;
		// Pending fall must be dropped
		repeat (20) begin
			@(posedge mclk);
			if (relayOut[4] !== 1'b1) n++;
		end
		check("cancel", n, 0);
		ahbWr(DLY_BASE + 8'h14, 32'hFFFF_FFFF);
		ahbRd(DLY_BASE + 8'h14, 32'h270F_EA60);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rst_b <= 1;
		@(posedge mclk);
		resetValues;
		busHold;
		fallback;
		safety;
		holdCancel;
		report_and_stop;
	end
endmodule // relay_output_conditioner_test
`default_nettype wire
